// file: design/ctm_cycle_timer.v
// Purpose: counts a nanosecond duration down in clock periods
// Assumes: one clock; duration loaded with i_load
// Notes:   rounds up to whole cycles, least one cycle
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defs.vh"
module ctm_cycle_timer
#(
  parameter W = 16
)
(
  input  wire         i_clk,   // clock
  input  wire         i_rst,   // sync reset
  input  wire         i_load,  // start pulse
  input  wire [W-1:0] i_ns,    // duration ns
  output wire         o_done   // pulse at end
);
  reg  [W-1:0] cnt_reg;
  reg          run_reg;
  wire [31:0]  cyc_full = ({{(32-W){1'b0}}, i_ns} + `CTM_CLK_NS - 1) / `CTM_CLK_NS;
  wire [W-1:0] cyc      = cyc_full[W-1:0];

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_reg <= {W{1'b0}};
      run_reg <= 1'b0;
    end
    else if (i_load)
    begin
      cnt_reg <= (cyc == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : cyc;
      run_reg <= 1'b1;
    end
    else if (run_reg)
    begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      if (cnt_reg == {{(W-1){1'b0}}, 1'b1})
        run_reg <= 1'b0;
    end
  end
  assign o_done = run_reg && (cnt_reg == {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// file: design/ctm_defs.vh
// Purpose: constants for the instruction timing model
// Assumes: times held in nanoseconds, clock 40 MHz (25 ns)
// Notes:   memory types: 0 bipolar, 1 8K core, 2 16K core
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH

`define CTM_CLK_NS        25
// instruction classes
`define CTM_CLS_DOUBLE    3'd0
`define CTM_CLS_MOVE      3'd1
`define CTM_CLS_SINGLE    3'd2
`define CTM_CLS_NEGATE    3'd3
`define CTM_CLS_SHIFT     3'd4
`define CTM_CLS_CONTROL   3'd5
`define CTM_CLS_WAIT      3'd6
// memory types
`define CTM_MEM_BIPOLAR   2'd0
`define CTM_MEM_CORE8K    2'd1
`define CTM_MEM_CORE16K   2'd2
// fixed increments, poll period, latency bound and service times in ns
`define CTM_MMU_NS        90
`define CTM_ODD_NS        150
`define CTM_CORE8_SRC_NS  70
`define CTM_CORE16_SRC_NS 85
`define CTM_PC8_NS        230
`define CTM_PC16_NS       220
`define CTM_PCBIP_NS      300
`define CTM_NEG_ODD_NS    120
`define CTM_SHIFT_NS      150
`define CTM_WAIT_POLL_NS  300
`define CTM_LAT_MAX_NS    12620
`define CTM_SVC16_NS      5440
`define CTM_SVC8_NS       4950
`define CTM_SVCBIP_NS     2250

`endif

// file: design/ctm_table_rom.v
// Purpose: phase time and memory cycle table
// Assumes: index = {memory type, addressing mode}
// Notes:   read data registered; DST selects the destination column set
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defs.vh"
module ctm_table_rom
#(
  parameter DST = 0
)
(
  input  wire        i_clk,      // clock
  input  wire [1:0]  i_mem,      // memory type
  input  wire [2:0]  i_mode,     // addressing mode
  output reg  [11:0] o_time_ns,  // address phase time
  output reg  [2:0]  o_cycles    // memory cycles
);
  // ----------------------------------------------------------------
  // lookup of address phase time
  // ----------------------------------------------------------------
  // source and destination share values except the 16K core column
  // at modes 1,2, where the destination phase is shorter
  always @(posedge i_clk)
  begin
    case ({i_mem, i_mode})
      5'h00, 5'h08, 5'h10: o_time_ns <= 12'd0;
      5'h01, 5'h02: o_time_ns <= 12'd300;
      5'h03: o_time_ns <= 12'd750;
      5'h04: o_time_ns <= 12'd450;
      5'h05: o_time_ns <= 12'd900;
      5'h06: o_time_ns <= 12'd600;
      5'h07: o_time_ns <= 12'd1050;
      5'h09, 5'h0a: o_time_ns <= 12'd830;
      5'h0b: o_time_ns <= 12'd1810;
      5'h0c: o_time_ns <= 12'd980;
      5'h0d: o_time_ns <= 12'd1960;
      5'h0e: o_time_ns <= 12'd1730;
      5'h0f: o_time_ns <= 12'd2710;
      5'h11, 5'h12: o_time_ns <= (DST != 0) ? 12'd860 : 12'd890;
      5'h13: o_time_ns <= 12'd1920;
      5'h14: o_time_ns <= 12'd1040;
      5'h15: o_time_ns <= 12'd2070;
      5'h16: o_time_ns <= 12'd1860;
      5'h17: o_time_ns <= 12'd2890;
      default: o_time_ns <= 12'd0;
    endcase
    case (i_mode)
      3'd0:    o_cycles <= 3'd0;
      3'd1, 3'd2, 3'd4: o_cycles <= 3'd1;
      3'd7:    o_cycles <= 3'd3;
      default: o_cycles <= 3'd2;
    endcase
  end
endmodule
`default_nettype wire

// file: design/ctm_timing_model.v
// Purpose: instruction duration model with interrupt acknowledge timing
// Assumes: one instruction presented at a time with i_start
// Notes:   times computed in ns then counted in 25 ns cycles
//          the acknowledge cycle counts as the first service cycle
//          a wait ends only on a poll tick with a request seen
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defs.vh"
module ctm_timing_model
#(
  parameter [1:0] MEM_TYPE = `CTM_MEM_CORE16K
)
(
  input  wire        I_REF_CLK,     // 40 MHz clock
  input  wire        I_RST,         // sync reset, high
  input  wire        i_start,       // start instruction
  input  wire [2:0]  i_class,       // instruction class
  input  wire [2:0]  i_src_mode,    // source mode
  input  wire [2:0]  i_dst_mode,    // destination mode
  input  wire        i_dst_pc,      // destination is PC
  input  wire        i_odd_byte,    // odd byte operand
  input  wire [4:0]  i_shift_cnt,   // shift count
  input  wire [11:0] i_ef_ns,       // base execute time
  input  wire [2:0]  i_ef_cycles,   // execute cycles
  input  wire        i_mmu_on,      // memory management on
  input  wire        i_irq_async,   // bus interrupt request pin
  output wire        o_busy,        // instruction or service running
  output reg         o_done,        // instruction end pulse
  output reg  [15:0] o_instr_ns,    // last duration ns
  output reg         o_irq_ack,     // acknowledge pulse
  output reg         o_svc_busy,    // service in progress
  output reg         o_svc_done     // handler fetch pulse
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_LOOK = 5'b00010;
  localparam [4:0] S_RUN  = 5'b00100;
  localparam [4:0] S_WAIT = 5'b01000;
  localparam [4:0] S_SVC  = 5'b10000;

  // full width constants, cut on purpose where they meet narrow nets
  localparam [31:0] POLL_FULL = `CTM_WAIT_POLL_NS / `CTM_CLK_NS;
  localparam [31:0] SVC_FULL  = (MEM_TYPE == `CTM_MEM_BIPOLAR) ? `CTM_SVCBIP_NS :
                                (MEM_TYPE == `CTM_MEM_CORE8K) ? `CTM_SVC8_NS : `CTM_SVC16_NS;
  // the acknowledge cycle is the first cycle of service
  localparam [31:0] SVC_LOAD  = SVC_FULL - `CTM_CLK_NS;

  reg  [4:0]  state_reg, state_next;
  reg  [2:0]  cls_reg, sm_reg, dm_reg, efc_reg;
  reg         pc_reg, odd_reg, mmu_reg;
  reg  [4:0]  sh_reg;
  reg  [11:0] ef_reg;
  reg  [2:0]  irq_sync_reg;
  reg  [3:0]  poll_reg;
  reg         ld_reg;
  reg  [15:0] load_ns;
  reg         irq_reg;
  wire        irq = irq_reg;
  wire [11:0] src_ns, dst_ns;
  wire [2:0]  src_cyc, dst_cyc;
  wire        tmr_done;
  wire [3:0]  poll_cyc = POLL_FULL[3:0];

  // cut a time to its low 16 bits
  function [15:0] ctm_w16;
    input [31:0] v;
    begin
      ctm_w16 = v[15:0];
    end
  endfunction

  // destination modes that carry the core source-mode adder
  function ctm_core_adj;
    input [2:0] mode;
    begin
      case (mode)
        3'd1, 3'd2, 3'd3, 3'd6, 3'd7: ctm_core_adj = 1'b1;
        default:                      ctm_core_adj = 1'b0;
      endcase
    end
  endfunction

  // program counter destination penalty, core memories only
  function [31:0] ctm_pc_pen;
    input [1:0] mem;
    begin
      case (mem)
        `CTM_MEM_CORE8K:  ctm_pc_pen = `CTM_PC8_NS;
        `CTM_MEM_CORE16K: ctm_pc_pen = `CTM_PC16_NS;
        default:          ctm_pc_pen = 32'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // address phase lookups
  // ----------------------------------------------------------------
  ctm_table_rom u_src
  (
    .i_clk     (I_REF_CLK),
    .i_mem     (MEM_TYPE),
    .i_mode    (i_src_mode),
    .o_time_ns (src_ns),
    .o_cycles  (src_cyc)
  );
  ctm_table_rom #(.DST(1)) u_dst
  (
    .i_clk     (I_REF_CLK),
    .i_mem     (MEM_TYPE),
    .i_mode    (i_dst_mode),
    .o_time_ns (dst_ns),
    .o_cycles  (dst_cyc)
  );

  // ----------------------------------------------------------------
  // duration arithmetic
  // ----------------------------------------------------------------
  // the composition happens once in S_LOOK, after the ROM latency
  reg [31:0] s_t, d_t, e_t, cyc_t;
  always @*
  begin
    s_t = {20'h0, src_ns};
    d_t = {20'h0, dst_ns};
    e_t = {20'h0, ef_reg};
    if (odd_reg && dm_reg != 3'd0)
      d_t = d_t + `CTM_ODD_NS;
    if (ctm_core_adj(dm_reg) && sm_reg != 3'd0 && MEM_TYPE == `CTM_MEM_CORE8K)
      d_t = d_t + `CTM_CORE8_SRC_NS;
    if (ctm_core_adj(dm_reg) && sm_reg != 3'd0 && MEM_TYPE == `CTM_MEM_CORE16K)
      d_t = d_t + `CTM_CORE16_SRC_NS;
    if (cls_reg == `CTM_CLS_DOUBLE && dm_reg == 3'd0 && pc_reg)
      e_t = e_t + ctm_pc_pen(MEM_TYPE);
    if (cls_reg == `CTM_CLS_SINGLE && dm_reg == 3'd0 && pc_reg && MEM_TYPE == `CTM_MEM_BIPOLAR)
      e_t = e_t + `CTM_PCBIP_NS;
    if (cls_reg == `CTM_CLS_NEGATE && dm_reg != 3'd0 && odd_reg)
      e_t = e_t + `CTM_NEG_ODD_NS;
    if (cls_reg == `CTM_CLS_SHIFT)
      e_t = e_t + `CTM_SHIFT_NS * sh_reg;
    cyc_t = {29'h0, efc_reg};
    case (cls_reg)
      `CTM_CLS_DOUBLE:
      begin
        load_ns = ctm_w16(s_t + d_t + e_t);
        cyc_t = cyc_t + src_cyc + dst_cyc;
      end
      `CTM_CLS_MOVE:
      begin
        load_ns = ctm_w16(s_t + e_t);
        cyc_t = cyc_t + src_cyc;
      end
      `CTM_CLS_SINGLE, `CTM_CLS_NEGATE, `CTM_CLS_SHIFT:
      begin
        load_ns = ctm_w16(d_t + e_t);
        cyc_t = cyc_t + dst_cyc;
      end
      default:
        load_ns = ctm_w16(e_t);
    endcase
    if (mmu_reg)
      load_ns = ctm_w16(load_ns + `CTM_MMU_NS * cyc_t);
  end

  // service time by memory type, less the acknowledge cycle, so the
  // handler fetch lands inside the bound
  wire [15:0] svc_ns = SVC_LOAD[15:0];

  // ----------------------------------------------------------------
  // duration timer
  // ----------------------------------------------------------------
  wire tmr_load = ld_reg;
  // the registered duration is used, not the live sum: the tables
  // follow the mode pins, which may move once the start is taken
  wire [15:0] tmr_ns = (state_reg == S_SVC) ? svc_ns : o_instr_ns;
  ctm_cycle_timer #(.W(16)) u_tmr
  (
    .i_clk  (I_REF_CLK),
    .i_rst  (I_RST),
    .i_load (tmr_load),
    .i_ns   (tmr_ns),
    .o_done (tmr_done)
  );

  // ----------------------------------------------------------------
  // request synchroniser
  // ----------------------------------------------------------------
  // three flops; the level moves only once the last two agree, so a
  // metastable first stage never reaches the state machine
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      irq_sync_reg <= 3'b000;
      irq_reg      <= 1'b0;
    end
    else
    begin
      irq_sync_reg <= {irq_sync_reg[1:0], i_irq_async};
      if (irq_sync_reg[1] == irq_sync_reg[2])
        irq_reg <= irq_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (irq)
          state_next = S_SVC;
        else if (i_start)
          state_next = S_LOOK;
      S_LOOK:
        state_next = (cls_reg == `CTM_CLS_WAIT) ? S_WAIT : S_RUN;
      S_RUN:
        if (tmr_done)
          state_next = irq ? S_SVC : S_IDLE;
      S_WAIT:
        if (irq && poll_reg == 4'd0)
          state_next = S_SVC;
      S_SVC:
        if (tmr_done && !ld_reg)
          state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state, capture and outputs
  // ----------------------------------------------------------------
  // worst case acknowledge is the longest instruction, bounded by
  // the 16 bit ns duration (covers 12.62 us)
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      state_reg <= S_IDLE;
      cls_reg <= 3'd0;
      sm_reg <= 3'd0;
      dm_reg <= 3'd0;
      efc_reg <= 3'd0;
      pc_reg <= 1'b0;
      odd_reg <= 1'b0;
      mmu_reg <= 1'b0;
      sh_reg <= 5'd0;
      ef_reg <= 12'd0;
      poll_reg <= 4'd0;
      ld_reg <= 1'b0;
      o_done <= 1'b0;
      o_instr_ns <= 16'h0000;
      o_irq_ack <= 1'b0;
      o_svc_busy <= 1'b0;
      o_svc_done <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ld_reg <= 1'b0;
      o_done <= 1'b0;
      o_irq_ack <= 1'b0;
      o_svc_done <= 1'b0;
      if (state_reg == S_IDLE && i_start && !irq)
      begin
        cls_reg <= i_class;
        sm_reg <= i_src_mode;
        dm_reg <= i_dst_mode;
        pc_reg <= i_dst_pc;
        odd_reg <= i_odd_byte;
        sh_reg <= i_shift_cnt;
        ef_reg <= i_ef_ns;
        efc_reg <= i_ef_cycles;
        mmu_reg <= i_mmu_on;
      end
      if (state_reg == S_LOOK)
      begin
        o_instr_ns <= load_ns;
        ld_reg <= (cls_reg != `CTM_CLS_WAIT);
        poll_reg <= poll_cyc - 4'd1;
      end
      if (state_reg == S_WAIT)
        poll_reg <= (poll_reg == 4'd0) ? poll_cyc - 4'd1 : poll_reg - 4'd1;
      if (state_reg == S_RUN && tmr_done)
        o_done <= 1'b1;
      if (state_next == S_SVC && state_reg != S_SVC)
      begin
        o_irq_ack <= 1'b1;
        o_svc_busy <= 1'b1;
        ld_reg <= 1'b1;
        if (state_reg == S_WAIT)
          o_done <= 1'b1;
      end
      if (state_reg == S_SVC && tmr_done && !ld_reg)
      begin
        o_svc_busy <= 1'b0;
        o_svc_done <= 1'b1;
      end
    end
  end

  assign o_busy = (state_reg != S_IDLE);
endmodule
`default_nettype wire

// file: tb/ctm_checker.sv
// Purpose: port checks for the instruction timing model
// Assumes: one clock, sync reset high, 25 ns period
// Notes:   service bound follows MEM_TYPE
`timescale 1ns/1ps
`default_nettype none
module ctm_checker
#(
  parameter [1:0] MEM_TYPE = 2'h2
)
(
  input wire logic        I_REF_CLK,   // clock
  input wire logic        I_RST,       // reset
  input wire logic        i_start,     // start
  input wire logic [2:0]  i_class,     // class
  input wire logic        i_irq_async, // request
  input wire logic        o_busy,      // busy
  input wire logic        o_done,      // done
  input wire logic [15:0] o_instr_ns,  // duration
  input wire logic        o_irq_ack,   // ack
  input wire logic        o_svc_busy,  // service
  input wire logic        o_svc_done   // handler fetch
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  localparam int SVC = (MEM_TYPE == 2'h2) ? 218 : (MEM_TYPE == 2'h1) ? 198 : 90;
  logic        wait_reg; // last accepted start was a wait
  logic [11:0] len_reg;  // cycles since accepted start
  logic [16:0] n_ns;
  logic [11:0] n_exp;
  // done trails the start edge by 2 plus whole periods, one at least
  assign n_ns  = ({1'b0, o_instr_ns} + 17'h00018) / 17'h00019;
  assign n_exp = (n_ns == 17'h0) ? 12'h4 : n_ns[11:0] + 12'h3;
  // a wait ends on a request, so its length is not checked
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      wait_reg <= 1'b0;
      len_reg  <= 12'h0;
    end
    else if (i_start && !o_busy)
    begin
      wait_reg <= (i_class == 3'h6);
      len_reg  <= 12'h1;
    end
    else
      len_reg <= len_reg + 12'h1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  a_done_single: assert property (o_done |=> !o_done)
    else $error("done pulse held");
  a_instr_len: assert property ((o_done && !wait_reg) |-> len_reg == n_exp)
    else $error("instruction length wrong");
  a_start_busy: assert property ((i_start && !o_busy && !i_irq_async && !o_svc_busy) |=> o_busy)
    else $error("start not taken");
  a_ack_between: assert property ((o_irq_ack && !wait_reg) |-> (o_done || $past(o_done) || !$past(o_busy)))
    else $error("ack inside instruction");
  a_ack_single: assert property (o_irq_ack |=> !o_irq_ack)
    else $error("ack pulse held");
  a_svc_bound: assert property (o_irq_ack |-> ##[1:SVC] o_svc_done)
    else $error("service too long");
  a_svc_hold: assert property (o_svc_done |-> $past(o_svc_busy))
    else $error("service end without service");
  a_latency_max: assert property ($rose(i_irq_async) |-> ##[0:520] (o_irq_ack || o_svc_busy))
    else $error("request latency too long");
  a_wait_poll: assert property ((wait_reg && o_busy && $rose(i_irq_async)) |-> ##[1:18] o_irq_ack)
    else $error("wait poll too slow");
  c_done: cover property (o_done && !wait_reg);
  c_wait_ack: cover property (wait_reg && o_irq_ack);
  c_svc: cover property (o_svc_done);
endmodule
bind ctm_timing_model ctm_checker #(.MEM_TYPE(MEM_TYPE)) u_chk
(
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .i_start(i_start), .i_class(i_class),
  .i_irq_async(i_irq_async), .o_busy(o_busy), .o_done(o_done), .o_instr_ns(o_instr_ns),
  .o_irq_ack(o_irq_ack), .o_svc_busy(o_svc_busy), .o_svc_done(o_svc_done)
);
`default_nettype wire

// file: tb/ctm_irq_source.sv
// Purpose: peripheral asking for interrupt service
// Assumes: one clock shared with the device
// Notes:   the bench decides when, so prompt and late requests both occur
`timescale 1ns/1ps
`default_nettype none
module ctm_irq_source
(
  input  wire logic i_clk,   // clock
  input  wire logic i_rst,   // sync reset
  input  wire logic i_raise, // bench asks for service
  input  wire logic i_ack,   // device acknowledge
  output var  logic o_req    // request level
);
  // a request is a level held until acknowledged, never withdrawn early
  always @(posedge i_clk)
  begin
    if (i_rst || i_ack)
      o_req <= 1'b0;
    else if (i_raise)
      o_req <= 1'b1;
  end
endmodule
`default_nettype wire

// file: tb/ctm_timing_model_test.sv
// Purpose: self-checking bench for the timing model, 16K core
// Assumes: inputs change on the falling edge
// Notes:   expected figures worked out by hand from phase times
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0d got %0d", nm, e, g); end end
module ctm_timing_model_test;
  logic        clk, rst, start, pc, odd, mmu, raise, irq, busy, done, ack, sbusy, sdone;
  logic [2:0]  cls, srcm, dstm, efc;
  logic [4:0]  sh;
  logic [11:0] ef;
  logic [15:0] ins, ins_b;
  logic        start_b;
  int          mismatches, n_tests, k, td, ta;

  ctm_timing_model dut
  (
    .I_REF_CLK(clk), .I_RST(rst), .i_start(start), .i_class(cls), .i_src_mode(srcm),
    .i_dst_mode(dstm), .i_dst_pc(pc), .i_odd_byte(odd), .i_shift_cnt(sh), .i_ef_ns(ef),
    .i_ef_cycles(efc), .i_mmu_on(mmu), .i_irq_async(irq), .o_busy(busy), .o_done(done),
    .o_instr_ns(ins), .o_irq_ack(ack), .o_svc_busy(sbusy), .o_svc_done(sdone)
  );
  ctm_irq_source u_src
  (
    .i_clk(clk), .i_rst(rst), .i_raise(raise), .i_ack(ack), .o_req(irq)
  );
  // second copy on bipolar memory, run only by its own scenario
  ctm_timing_model #(.MEM_TYPE(2'h0)) dut_bip
  (
    .I_REF_CLK(clk), .I_RST(rst), .i_start(start_b), .i_class(cls), .i_src_mode(srcm),
    .i_dst_mode(dstm), .i_dst_pc(pc), .i_odd_byte(odd), .i_shift_cnt(sh), .i_ef_ns(ef),
    .i_ef_cycles(efc), .i_mmu_on(mmu), .i_irq_async(1'b0), .o_busy(), .o_done(),
    .o_instr_ns(ins_b), .o_irq_ack(), .o_svc_busy(), .o_svc_done()
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one instruction; checks duration and done timing
  task automatic run(input [2:0] c, s, d, input p, o, input [4:0] n, input [11:0] e,
                     input [2:0] ec, input m, input [15:0] x);
    int cnt;
    {cls, srcm, dstm, pc, odd, sh, ef, efc, mmu} = {c, s, d, p, o, n, e, ec, m};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    cnt = 0;
    while (done !== 1'b1 && cnt < 400)
    begin
      @(negedge clk);
      cnt++;
    end
    `CHK("instr_ns", x, ins)
    `CHK("cycles", 2 + (x + 24) / 25, cnt)
    @(negedge clk);
  endtask
  // start, raise a request, follow it to the handler fetch
  task automatic follow(input [2:0] c, input int lead);
    {cls, srcm, dstm, ef, efc, mmu} = {c, 3'h0, 3'h0, 12'h7d0, 3'h1, 1'b0};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (lead) @(negedge clk);
    `CHK("busy_before_req", 1'b1, busy)
    raise = 1'b1;
    td = -1;
    ta = -1;
    for (k = 0; k < 800; k++)
    begin
      @(negedge clk);
      raise = 1'b0;
      if (done === 1'b1 && td < 0) td = k;
      if (ack === 1'b1) ta = k;
      if (sdone === 1'b1) break;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_phases;
    run(3'h0, 3'h1, 3'h1, 0, 0, 0, 12'h3e8, 3'h2, 0, 16'd2835);
    run(3'h0, 3'h1, 3'h0, 0, 0, 0, 12'h3e8, 3'h2, 0, 16'd1890);
    run(3'h1, 3'h1, 3'h1, 0, 0, 0, 12'h3e8, 3'h2, 0, 16'd1890);
    run(3'h5, 3'h1, 3'h1, 0, 0, 0, 12'h3e8, 3'h2, 0, 16'd1000);
    run(3'h2, 3'h0, 3'h1, 0, 0, 0, 12'h3e8, 3'h2, 0, 16'd1860);
  endtask
  task automatic t_adders;
    run(3'h0, 3'h0, 3'h1, 0, 1, 0, 12'h3e8, 3'h2, 0, 16'd2010);
    run(3'h0, 3'h0, 3'h0, 0, 1, 0, 12'h3ca, 3'h1, 0, 16'd970);
    run(3'h0, 3'h0, 3'h0, 1, 0, 0, 12'h3ca, 3'h1, 0, 16'd1190);
    run(3'h3, 3'h0, 3'h1, 0, 1, 0, 12'h7c6, 3'h2, 0, 16'd3120);
    run(3'h4, 3'h0, 3'h0, 0, 0, 5, 12'h53c, 3'h1, 0, 16'd2090);
    run(3'h4, 3'h0, 3'h0, 0, 0, 31, 12'h53c, 3'h1, 0, 16'd5990);
    run(3'h5, 3'h0, 3'h0, 0, 0, 0, 12'h3e8, 3'h2, 1, 16'd1180);
    run(3'h0, 3'h1, 3'h1, 0, 0, 0, 12'h3e8, 3'h2, 1, 16'd3195);
  endtask
  // bipolar copy: program counter penalty in single, none in double
  task automatic t_bipolar;
    {cls, srcm, dstm, pc, odd, sh, ef, efc, mmu} = {3'h2, 3'h0, 3'h0, 1'b1, 1'b0, 5'h00, 12'h12c, 3'h1, 1'b0};
    start_b = 1'b1;
    @(negedge clk);
    start_b = 1'b0;
    repeat (30) @(negedge clk);
    `CHK("bip_single_pc", 16'd600, ins_b)
    cls = 3'h0;
    start_b = 1'b1;
    @(negedge clk);
    start_b = 1'b0;
    repeat (30) @(negedge clk);
    `CHK("bip_double_pc", 16'd300, ins_b)
  endtask
  // request lands mid-instruction; ack must wait for the end
  task automatic t_irq_mid;
    follow(3'h5, 10);
    `CHK("ack_at_end", 1'b1, td > 20 && ta >= 0 && ta + 1 >= td)
    `CHK("ack_latency", 1'b1, ta <= 509)
    `CHK("svc_time", 1'b1, k > ta && k - ta <= 218)
    `CHK("svc_released", 1'b0, sbusy)
    repeat (8) @(negedge clk);
  endtask
  // wait loops on its poll tick until a request shows
  task automatic t_wait;
    follow(3'h6, 40);
    `CHK("wait_ack", 1'b1, ta >= 0 && ta <= 18)
    `CHK("wait_svc", 1'b1, k > ta && k - ta <= 218)
    repeat (8) @(negedge clk);
  endtask

  // ----------------------------------------
  // clock, sequence, watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    {rst, start, pc, odd, mmu, raise, cls, srcm, dstm, efc, sh, ef} = {1'b1, 34'h0};
    start_b = 1'b0;
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_phases;
    t_adders;
    t_bipolar;
    t_irq_mid;
    t_wait;
    close_out;
  end
  // the whole run needs well under 3000 cycles
  initial
  begin
    #500000;
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
